// ===== logic/bld_map.svh
// constants for the byte load group executor: opcodes, field positions, t-state counts
`ifndef BLD_MAP_SVH
`define BLD_MAP_SVH
`define BLD_PFX_FIRST      8'hDD
`define BLD_PFX_SECOND     8'hFD
`define BLD_OP_IMM_STORE   8'h36
`define BLD_OP_HALT        8'h76
`define BLD_GRP_MOVE       2'b01
`define BLD_GRP_LOW        2'b00
`define BLD_LOW_IMM        3'b110
`define BLD_MEM_FIELD      3'b110
`define BLD_DST_HI         5
`define BLD_DST_LO         3
`define BLD_SRC_HI         2
`define BLD_SRC_LO         0
`define BLD_REG_B          3'b000
`define BLD_REG_C          3'b001
`define BLD_REG_D          3'b010
`define BLD_REG_E          3'b011
`define BLD_REG_H          3'b100
`define BLD_REG_L          3'b101
`define BLD_REG_A          3'b111
`define BLD_T_FETCH        3'd4
`define BLD_T_MEM          3'd3
`define BLD_T_ADD          3'd5
`define BLD_RST_WORD       16'h0000
`define BLD_RST_BYTE       8'h00
`endif

// ===== logic/bld_pkg.sv
// types for the byte load group executor
package bld_pkg;
  typedef enum logic [5:0] {
    BLD_FETCH = 6'b00_0001,
    BLD_PFX2  = 6'b00_0010,
    BLD_OPND  = 6'b00_0100,
    BLD_ADDR  = 6'b00_1000,
    BLD_MEM   = 6'b01_0000,
    BLD_IDLE  = 6'b10_0000
  } bld_state_t;
  typedef enum logic [1:0] {
    BLD_PTR_PAIR   = 2'b00,
    BLD_PTR_FIRST  = 2'b01,
    BLD_PTR_SECOND = 2'b10
  } bld_ptr_t;
endpackage

// ===== logic/bld_tcount.sv
// t-state counter that marks the last clock of each machine cycle
`timescale 1ns/1ns
`default_nettype none
module bld_tcount #(
  parameter int W = 3
) (
  input  wire logic         core_clk_in,
  input  wire logic         reset_in,
  input  wire logic [W-1:0] len_in,
  output logic              last_out
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  assign last_out = (cnt_ff == len_in - W'(1));

  always_comb begin
    nxt_cnt = last_out ? '0 : cnt_ff + W'(1);
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule
`default_nettype wire

// ===== logic/bld_exec.sv
// byte load group executor: decode, machine-cycle sequencing and register file
`timescale 1ns/1ns
`default_nettype none
`include "bld_map.svh"

module bld_exec #(
  parameter logic [15:0] RESET_PC = `BLD_RST_WORD
) (
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic [7:0]  mem_rdata_in,
  input  wire logic [15:0] ix_in,
  input  wire logic [15:0] iy_in,
  input  wire logic [7:0]  flags_in,
  output logic [15:0]      mem_addr_out,
  output logic [7:0]       mem_wdata_out,
  output logic             mem_rd_out,
  output logic             mem_wr_out,
  output logic             m1_out,
  output logic [7:0]       flags_out,
  output logic [7:0]       reg_a_out,
  output logic [7:0]       reg_h_out,
  output logic [7:0]       reg_l_out,
  output logic             illegal_out
);
  import bld_pkg::*;

  bld_state_t   st_ff,   nxt_st;
  bld_ptr_t     ptr_ff,  nxt_ptr;
  logic [15:0]  pc_ff,   nxt_pc;
  logic [7:0]   op_ff,   nxt_op;
  logic [7:0]   disp_ff, nxt_disp;
  logic [15:0]  ea_ff,   nxt_ea;
  logic         wr_ff,   nxt_wr;
  logic         imm_ff,  nxt_imm;
  logic [7:0]   data_ff, nxt_data;
  logic [2:0]   opnd_ff, nxt_opnd;
  logic [7:0]   regs_ff [8];
  logic [7:0]   flags_ff;
  logic         rf_we;
  logic [2:0]   rf_sel;
  logic [7:0]   rf_data;
  logic [15:0]  addr_ff, nxt_addr;
  logic [7:0]   wd_ff,   nxt_wd;
  logic         rd_ff,   nxt_rd;
  logic         wrs_ff,  nxt_wrs;
  logic         m1_ff,   nxt_m1;
  logic         ill_ff,  nxt_ill;
  logic [2:0]   mlen;
  logic         mlast;
  logic [15:0]  pair;
  logic [15:0]  idx;
  logic [1:0]   grp;
  logic [2:0]   dst;
  logic [2:0]   src;

  // each state is one machine cycle; its length picks the t-state count
  always_comb begin
    unique case (st_ff)
      BLD_FETCH, BLD_PFX2: mlen = `BLD_T_FETCH;
      BLD_ADDR:            mlen = `BLD_T_ADD;
      BLD_IDLE:            mlen = 3'd1;
      default:             mlen = `BLD_T_MEM;
    endcase
  end

  bld_tcount #(
    .W (3)
  ) u_tcount (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .len_in      (mlen),
    .last_out    (mlast)
  );

  assign pair = {regs_ff[`BLD_REG_H], regs_ff[`BLD_REG_L]};
  assign idx  = (ptr_ff == BLD_PTR_FIRST) ? ix_in : iy_in;
  assign grp  = op_ff[7:6];
  assign dst  = op_ff[`BLD_DST_HI:`BLD_DST_LO];
  assign src  = op_ff[`BLD_SRC_HI:`BLD_SRC_LO];

  always_comb begin
    nxt_st   = st_ff;
    nxt_ptr  = ptr_ff;
    nxt_pc   = pc_ff;
    nxt_op   = op_ff;
    nxt_disp = disp_ff;
    nxt_ea   = ea_ff;
    nxt_wr   = wr_ff;
    nxt_imm  = imm_ff;
    nxt_data = data_ff;
    nxt_opnd = opnd_ff;
    nxt_ill  = 1'b0;
    rf_we    = 1'b0;
    rf_sel   = dst;
    rf_data  = data_ff;
    if (mlast) begin
      unique case (st_ff)
        BLD_IDLE: begin
          nxt_st = BLD_FETCH;
        end
        BLD_FETCH, BLD_PFX2: begin
          // opcode byte arrives at the end of the m1 cycle
          nxt_pc = pc_ff + 16'd1;
          if (st_ff == BLD_FETCH && mem_rdata_in == `BLD_PFX_FIRST) begin
            nxt_ptr = BLD_PTR_FIRST;
            nxt_st  = BLD_PFX2;
          end else if (st_ff == BLD_FETCH && mem_rdata_in == `BLD_PFX_SECOND) begin
            nxt_ptr = BLD_PTR_SECOND;
            nxt_st  = BLD_PFX2;
          end else begin
            nxt_op  = mem_rdata_in;
            nxt_st  = BLD_FETCH;
            if (st_ff == BLD_FETCH) begin
              nxt_ptr = BLD_PTR_PAIR;
            end
            nxt_wr   = 1'b0;
            nxt_imm  = 1'b0;
            nxt_opnd = 3'd0;
            if (mem_rdata_in[7:6] == `BLD_GRP_MOVE && mem_rdata_in != `BLD_OP_HALT) begin
              if (mem_rdata_in[2:0] == `BLD_MEM_FIELD) begin
                // read from memory into register
                nxt_opnd = (st_ff == BLD_PFX2) ? 3'd1 : 3'd0;
                nxt_st   = (st_ff == BLD_PFX2) ? BLD_OPND : BLD_MEM;
                nxt_ea   = pair;
              end else if (mem_rdata_in[5:3] == `BLD_MEM_FIELD) begin
                nxt_wr   = 1'b1;
                nxt_opnd = (st_ff == BLD_PFX2) ? 3'd1 : 3'd0;
                nxt_st   = (st_ff == BLD_PFX2) ? BLD_OPND : BLD_MEM;
                nxt_ea   = pair;
              end else if (st_ff == BLD_FETCH) begin
                // register move finishes in the fetch cycle
                rf_we   = 1'b1;
                rf_sel  = mem_rdata_in[`BLD_DST_HI:`BLD_DST_LO];
                rf_data = regs_ff[mem_rdata_in[`BLD_SRC_HI:`BLD_SRC_LO]];
              end else begin
                nxt_ill = 1'b1;
              end
            end else if (mem_rdata_in[7:6] == `BLD_GRP_LOW && mem_rdata_in[2:0] == `BLD_LOW_IMM) begin
              nxt_imm = 1'b1;
              nxt_st  = BLD_OPND;
              if (mem_rdata_in == `BLD_OP_IMM_STORE) begin
                nxt_wr   = 1'b1;
                nxt_ea   = pair;
                nxt_opnd = 3'd1;
              end else if (st_ff == BLD_FETCH) begin
                nxt_opnd = 3'd1;
              end else begin
                nxt_ill = 1'b1;
                nxt_st  = BLD_FETCH;
              end
            end else begin
              // outside this group: skipped as a one-cycle no-op
              nxt_ill = 1'b1;
            end
          end
        end
        BLD_OPND: begin
          nxt_pc   = pc_ff + 16'd1;
          nxt_opnd = opnd_ff - 3'd1;
          if (ptr_ff != BLD_PTR_PAIR && opnd_ff != 3'd0) begin
            // displacement byte; an indexed immediate store reads its data during the add
            nxt_disp = mem_rdata_in;
            nxt_st   = BLD_ADDR;
          end else if (wr_ff) begin
            nxt_data = mem_rdata_in;
            nxt_st   = (ptr_ff == BLD_PTR_PAIR) ? BLD_MEM : BLD_ADDR;
          end else begin
            // immediate register load
            rf_we   = 1'b1;
            rf_data = mem_rdata_in;
            nxt_st  = BLD_FETCH;
          end
        end
        BLD_ADDR: begin
          // five-clock address add with sign-extended displacement
          nxt_ea = idx + {{8{disp_ff[7]}}, disp_ff};
          if (imm_ff) begin
            // data byte is fetched while the sum settles, keeping the store at five cycles
            nxt_data = mem_rdata_in;
            nxt_pc   = pc_ff + 16'd1;
          end
          nxt_st = BLD_MEM;
        end
        BLD_MEM: begin
          if (!wr_ff) begin
            rf_we   = 1'b1;
            rf_data = mem_rdata_in;
          end
          nxt_st = BLD_FETCH;
        end
        default: nxt_st = BLD_FETCH;
      endcase
    end
  end

  // bus drive for the cycle about to start, registered so outputs come from flops
  always_comb begin
    nxt_addr = addr_ff;
    nxt_wd   = wd_ff;
    nxt_rd   = rd_ff;
    nxt_wrs  = 1'b0;
    nxt_m1   = m1_ff;
    if (mlast) begin
      nxt_m1 = (nxt_st == BLD_FETCH || nxt_st == BLD_PFX2);
      nxt_rd = (nxt_st != BLD_ADDR || nxt_imm) && !(nxt_st == BLD_MEM && nxt_wr);
      unique case (nxt_st)
        BLD_MEM: begin
          nxt_addr = nxt_ea;
          nxt_wd   = nxt_imm ? nxt_data : regs_ff[(st_ff == BLD_FETCH || st_ff == BLD_PFX2) ?
                                                  nxt_op[2:0] : src];
          nxt_wrs  = nxt_wr;
        end
        BLD_ADDR: nxt_addr = nxt_imm ? nxt_pc : addr_ff;
        default:  nxt_addr = nxt_pc;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_ff   <= BLD_IDLE;
      ptr_ff  <= BLD_PTR_PAIR;
      pc_ff   <= RESET_PC;
      op_ff   <= `BLD_RST_BYTE;
      disp_ff <= `BLD_RST_BYTE;
      ea_ff   <= `BLD_RST_WORD;
      wr_ff   <= 1'b0;
      imm_ff  <= 1'b0;
      data_ff <= `BLD_RST_BYTE;
      opnd_ff <= 3'd0;
      addr_ff <= RESET_PC;
      wd_ff   <= `BLD_RST_BYTE;
      rd_ff   <= 1'b0;
      wrs_ff  <= 1'b0;
      m1_ff   <= 1'b0;
      ill_ff  <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      ptr_ff  <= nxt_ptr;
      pc_ff   <= nxt_pc;
      op_ff   <= nxt_op;
      disp_ff <= nxt_disp;
      ea_ff   <= nxt_ea;
      wr_ff   <= nxt_wr;
      imm_ff  <= nxt_imm;
      data_ff <= nxt_data;
      opnd_ff <= nxt_opnd;
      addr_ff <= nxt_addr;
      wd_ff   <= nxt_wd;
      rd_ff   <= nxt_rd;
      wrs_ff  <= nxt_wrs ? 1'b1 : (mlast ? 1'b0 : wrs_ff);
      m1_ff   <= nxt_m1;
      ill_ff  <= nxt_ill;
    end
  end

  // register file; index 110 is the memory slot and is never written
  for (genvar g = 0; g < 8; g++) begin : g_rf
    always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
        regs_ff[g] <= `BLD_RST_BYTE;
      end else if (rf_we && rf_sel == 3'(g) && 3'(g) != `BLD_MEM_FIELD) begin
        regs_ff[g] <= rf_data;
      end
    end
  end

  // flags are captured once after reset and then held untouched by this group
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      flags_ff <= `BLD_RST_BYTE;
    end else if (st_ff == BLD_IDLE) begin
      flags_ff <= flags_in;
    end
  end

  assign mem_addr_out  = addr_ff;
  assign mem_wdata_out = wd_ff;
  assign mem_rd_out    = rd_ff;
  assign mem_wr_out    = wrs_ff;
  assign m1_out        = m1_ff;
  assign flags_out     = flags_ff;
  assign reg_a_out     = regs_ff[`BLD_REG_A];
  assign reg_h_out     = regs_ff[`BLD_REG_H];
  assign reg_l_out     = regs_ff[`BLD_REG_L];
  assign illegal_out   = ill_ff;
endmodule
`default_nettype wire

// ===== verification/bld_exec_chk.sv
// port checks for the byte load group executor
`timescale 1ns/1ns
`default_nettype none
module bld_exec_chk (
  input wire logic        core_clk_in,
  input wire logic        reset_in,
  input wire logic [15:0] mem_addr_out,
  input wire logic [7:0]  mem_wdata_out,
  input wire logic        mem_rd_out,
  input wire logic        mem_wr_out,
  input wire logic        m1_out,
  input wire logic [7:0]  flags_out
);
  logic [2:0] run_ff;
  logic [2:0] nxt_run;
  // flags are captured once just after reset, so the first clocks are skipped
  always_comb nxt_run = reset_in ? 3'h0 : (run_ff == 3'h7) ? run_ff : run_ff + 3'h1;
  always_ff @(posedge core_clk_in) run_ff <= nxt_run;

  a_flags_kept: assert property (@(posedge core_clk_in) disable iff (reset_in)
    run_ff >= 3'h4 |-> $stable(flags_out)) else $error("flag byte changed");
  a_fetch_four: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $rose(m1_out) |-> m1_out [*4]) else $error("fetch cycle shorter than four clocks");
  a_opnd_three: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $fell(m1_out) && mem_rd_out |-> mem_rd_out [*3]) else $error("read cycle shorter than three clocks");
  a_add_five: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $fell(mem_rd_out) && !mem_wr_out |-> (!mem_rd_out && !mem_wr_out) [*5] ##1 (mem_rd_out || mem_wr_out))
    else $error("address add cycle not five clocks");
  a_wr_three: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $rose(mem_wr_out) |-> mem_wr_out [*3] ##1 !mem_wr_out) else $error("write cycle not three clocks");
  a_wr_steady: assert property (@(posedge core_clk_in) disable iff (reset_in)
    mem_wr_out && $past(mem_wr_out) |-> $stable(mem_addr_out) && $stable(mem_wdata_out))
    else $error("write address or data moved");
  a_wr_alone: assert property (@(posedge core_clk_in) disable iff (reset_in)
    mem_wr_out |-> !m1_out && !mem_rd_out) else $error("write overlaps a read");
  a_fetch_reads: assert property (@(posedge core_clk_in) disable iff (reset_in)
    m1_out |-> mem_rd_out) else $error("fetch without read strobe");
endmodule

bind bld_exec bld_exec_chk u_chk (.core_clk_in(core_clk_in), .reset_in(reset_in), .mem_addr_out(mem_addr_out),
  .mem_wdata_out(mem_wdata_out), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out), .m1_out(m1_out),
  .flags_out(flags_out));
`default_nettype wire

// ===== verification/bld_mem_model.sv
// behavioural memory on the far side of the processor bus
`timescale 1ns/1ns
`default_nettype none
module bld_mem_model (
  input  wire logic        core_clk_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        rd_in,
  input  wire logic        wr_in,
  output logic [7:0]       rdata_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_ff;
  // bus released outside reads: show the inverse of the last byte so stale data never matches
  always_comb rdata_out = rd_in ? mem[addr_in] : ~last_ff;
  // plain always: the bench preloads the array, which an always_ff would forbid
  always @(posedge core_clk_in) begin
    if (rd_in) last_ff <= mem[addr_in];
    if (wr_in) mem[addr_in] <= wdata_in;
  end
endmodule
`default_nettype wire

// ===== verification/bld_exec_tb.sv
// self-checking bench for the byte load group executor
`timescale 1ns/1ns
`default_nettype none
module bld_exec_tb;
  logic        core_clk_in, reset_in, rd, wr, m1, ill, ill_seen;
  logic [7:0]  rdata, flags_in, wdata, flags_out, reg_a, reg_h, reg_l;
  logic [15:0] addr, ix_in, iy_in;
  int          fail_count, samples_checked, cyc, last_cyc;
  logic [7:0]  prog [0:50] = '{8'h06, 8'h11, 8'h0E, 8'h22, 8'h16, 8'h33, 8'h1E, 8'h44, 8'h26, 8'h55,
    8'h2E, 8'h66, 8'h3E, 8'h77, 8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h26, 8'h80, 8'h2E, 8'h10,
    8'h7E, 8'h36, 8'hC3, 8'h3E, 8'h5C, 8'h77, 8'hDD, 8'h7E, 8'h05, 8'hFD, 8'h7E, 8'hFE, 8'hDD, 8'h77,
    8'h80, 8'hFD, 8'h77, 8'h7F, 8'hDD, 8'h36, 8'h03, 8'h9B, 8'hFD, 8'h36, 8'hFF, 8'h4E, 8'h80};

  bld_exec u_bld_exec (.core_clk_in(core_clk_in), .reset_in(reset_in), .mem_rdata_in(rdata), .ix_in(ix_in),
    .iy_in(iy_in), .flags_in(flags_in), .mem_addr_out(addr), .mem_wdata_out(wdata), .mem_rd_out(rd),
    .mem_wr_out(wr), .m1_out(m1), .flags_out(flags_out), .reg_a_out(reg_a), .reg_h_out(reg_h),
    .reg_l_out(reg_l), .illegal_out(ill));
  bld_mem_model u_bld_mem_model (.core_clk_in(core_clk_in), .addr_in(addr), .wdata_in(wdata), .rd_in(rd),
    .wr_in(wr), .rdata_out(rdata));

  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // gap is the clock count since the previous fetch waited for; zero skips the timing compare
  task automatic wait_fetch(input logic [15:0] a, input int gap);
    int n;
    n = 0;
    while (!(m1 === 1'b1 && addr === a) && n < 200) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n == 200) fail_count++;
    if (gap > 0) chk(16'(cyc - last_cyc), 16'(gap));
    last_cyc = cyc;
  endtask

  task automatic t_loads();
    wait_fetch(16'h0000, 0);
    wait_fetch(16'h0002, 7);
    wait_fetch(16'h000E, 42);
    chk({8'h00, reg_a}, 16'h0077);
    chk({reg_h, reg_l}, 16'h5566);
  endtask

  task automatic t_moves();
    for (int i = 0; i < 6; i++) begin
      wait_fetch(16'(15 + i), 4);
      chk({8'h00, reg_a}, 16'(8'h11 * (i + 1)));
    end
  endtask

  task automatic t_pair();
    wait_fetch(16'h0016, 7);
    wait_fetch(16'h0018, 7);
    chk({reg_h, reg_l}, 16'h8010);
    wait_fetch(16'h0019, 7);
    chk({8'h00, reg_a}, 16'h00A5);
    wait_fetch(16'h001B, 10);
    chk({8'h00, u_bld_mem_model.mem[16'h8010]}, 16'h00C3);
    wait_fetch(16'h001D, 7);
    wait_fetch(16'h001E, 7);
    chk({8'h00, u_bld_mem_model.mem[16'h8010]}, 16'h005C);
  endtask

  task automatic t_index();
    wait_fetch(16'h0021, 19);
    chk({8'h00, reg_a}, 16'h00E1);
    wait_fetch(16'h0024, 19);
    chk({8'h00, reg_a}, 16'h00D2);
    wait_fetch(16'h0027, 19);
    chk({8'h00, u_bld_mem_model.mem[16'h8F80]}, 16'h00D2);
    wait_fetch(16'h002A, 19);
    chk({8'h00, u_bld_mem_model.mem[16'hA07F]}, 16'h00D2);
    wait_fetch(16'h002E, 19);
    chk({8'h00, u_bld_mem_model.mem[16'h9003]}, 16'h009B);
    wait_fetch(16'h0032, 19);
    chk({8'h00, u_bld_mem_model.mem[16'h9FFF]}, 16'h004E);
    wait_fetch(16'h0033, 4);
    wait_fetch(16'h0034, 4);
    chk({15'h0000, ill_seen}, 16'h0001);
    chk({8'h00, flags_out}, 16'h00A5);
    // prefixed register move is refused: two fetches, accumulator untouched
    wait_fetch(16'h0036, 8);
    chk({8'h00, reg_a}, 16'h00D2);
  endtask

  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (ill === 1'b1) ill_seen <= 1'b1;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    reset_in = 1'b1;
    flags_in = 8'hA5;
    ix_in = 16'h9000;
    iy_in = 16'hA000;
    ill_seen = 1'b0;
    cyc = 0;
    fail_count = 0;
    samples_checked = 0;
    last_cyc = 0;
    for (int i = 0; i < 65536; i++) u_bld_mem_model.mem[i] = (i < 51) ? prog[i] : 8'h00;
    u_bld_mem_model.mem[16'h8010] = 8'hA5;
    u_bld_mem_model.mem[16'h9005] = 8'hE1;
    u_bld_mem_model.mem[16'h9FFE] = 8'hD2;
    u_bld_mem_model.mem[16'h0034] = 8'hDD;
    u_bld_mem_model.mem[16'h0035] = 8'h78;
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    t_loads();
    t_moves();
    t_pair();
    t_index();
    finish_test();
  end
endmodule
`default_nettype wire
